// [core/fps_pkg.sv]
// constants, states and status bit positions for the program/erase status block
// assumes a 40 MHz core clock and a command decoder on the same clock
package fps_pkg;
  // ==========================================
  // clock rate
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
  // ==========================================
  // timing, figures as printed
  localparam int unsigned PGM_SUS_TYP_US = 3;
  localparam int unsigned PGM_SUS_MAX_US = 10;
  localparam int unsigned ERS_SUS_TYP_US = 10;
  localparam int unsigned ERS_SUS_MAX_US = 30;
  localparam int unsigned ERS_LARGE_MS = 2000;
  localparam int unsigned ERS_MID_MS = 1600;
  localparam int unsigned ERS_SMALL_MS = 1200;
  // derived cycle counts; longest times round down, exact here
  localparam int unsigned PGM_SUS_TYP_CYC = PGM_SUS_TYP_US * CLK_MHZ;
  localparam int unsigned PGM_SUS_MAX_CYC = PGM_SUS_MAX_US * CLK_MHZ;
  localparam int unsigned ERS_SUS_TYP_CYC = ERS_SUS_TYP_US * CLK_MHZ;
  localparam int unsigned ERS_SUS_MAX_CYC = ERS_SUS_MAX_US * CLK_MHZ;
  localparam int unsigned ERS_LARGE_CYC = ERS_LARGE_MS * CLK_KHZ;
  localparam int unsigned ERS_MID_CYC = ERS_MID_MS * CLK_KHZ;
  localparam int unsigned ERS_SMALL_CYC = ERS_SMALL_MS * CLK_KHZ;
  // program time is not given; plain default
  localparam int unsigned PGM_CYC = 32'h0000_0190;
  // ==========================================
  // status bit positions
  localparam int unsigned SB_READY = 7;
  localparam int unsigned SB_ERS_SUSP = 6;
  localparam int unsigned SB_ERS_FAIL = 5;
  localparam int unsigned SB_PGM_FAIL = 4;
  localparam int unsigned SB_PEN_FAIL = 3;
  localparam int unsigned SB_PGM_SUSP = 2;
  localparam int unsigned SB_PROT_FAIL = 1;
  localparam int unsigned SB_TUNE = 0;
  // ==========================================
  // erase block size codes
  localparam logic [1:0] ERS_SZ_SMALL = 2'h0;
  localparam logic [1:0] ERS_SZ_MID = 2'h1;
  // pin order: chip enable_b, output enable_b, output disable_b, p/e enable
  localparam logic [3:0] PIN_RST = 4'hE;
  localparam logic [7:0] STATUS_RST = 8'h80;
  // ==========================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_PAUSING = 4'h4,
    ST_SUSP = 4'h8
  } fps_state_t;
endpackage : fps_pkg

// [core/fps_status.sv]
// program/erase controller with its status register, read over the data lines
// assumes a command decoder on i_mclk giving one-cycle command pulses,
// and raw chip enable, output enable, output disable and p/e enable pins
//
// Contract
// RULE1: status flags appear on the low eight data lines on a status read
// RULE2: status read content does not depend on the address presented
// RULE3: program, erase, protect and resume commands switch reads to status
// RULE4: status output refreshes on each output-enable or chip-enable reactivation
// RULE5: bit 7 reads 0 while the controller is busy, 1 when idle
// RULE6: after suspend, bit 7 reads 0 until the controller pauses
// RULE7: host polls bit 7 before looking at any other bit
// RULE8: host checks erase and program failure flags once idle
// RULE9: bit 6 reads 1 only while an erase is suspended
// RULE10: if the operation finishes before pausing, suspend flags stay 0
// RULE11: bit 2 reads 1 only while a program is suspended
// RULE12: resume clears the suspend flag and continues the paused operation
// RULE13: bit 5 sets when erase verification fails after all pulses
// RULE14: bit 4 sets when program, buffered program or code check fails
// RULE15: bit 3 sets on program or erase with the enable pin low
// RULE16: bit 1 sets on program or erase to a protected block
// RULE17: error bits stay set until clear-status or hardware reset
// RULE18: with an error bit set, new program or erase appears to fail
// RULE19: program pauses within 10 us of a suspend command
// RULE20: erase pauses within 30 us of a suspend command
// RULE21: block erase completes within 2, 1.6 or 1.2 seconds by size
// RULE22: bit 0 shows tuning lock, 0 locked, reads 0 after reset
// RULE23: after reset the controller is idle with all flags 0
module fps_status
  import fps_pkg::*;
#(
  parameter int unsigned ERS_LARGE = ERS_LARGE_CYC,
  parameter int unsigned ERS_MID = ERS_MID_CYC,
  parameter int unsigned ERS_SMALL = ERS_SMALL_CYC,
  parameter int unsigned PGM_TIME = PGM_CYC,
  parameter int unsigned PGM_PAUSE = PGM_SUS_TYP_CYC,
  parameter int unsigned ERS_PAUSE = ERS_SUS_TYP_CYC
)
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_chip_enable_b,
  input wire logic i_output_enable_b,
  input wire logic i_output_disable_pin_b,
  input wire logic i_program_erase_enable_pin,
  input wire logic i_cmd_program,
  input wire logic i_cmd_erase,
  input wire logic [1:0] i_erase_size,
  input wire logic i_cmd_protect,
  input wire logic i_cmd_read_status,
  input wire logic i_cmd_read_array,
  input wire logic i_cmd_clear_status,
  input wire logic i_cmd_suspend,
  input wire logic i_cmd_resume,
  input wire logic i_block_protected,
  input wire logic i_verify_fail,
  input wire logic i_code_check_fail,
  input wire logic i_tuning_unlocked,
  output logic [7:0] o_status_dq,
  output logic o_status_mode,
  output logic o_ready
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // pin synchronisers
  logic [3:0] pin_raw;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] pin_reg;
  assign pin_raw = {i_chip_enable_b, i_output_enable_b, i_output_disable_pin_b,
                    i_program_erase_enable_pin};
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      s1_reg <= PIN_RST;
      s2_reg <= PIN_RST;
      s3_reg <= PIN_RST;
    end
    else
    begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // a level is accepted only once two stages agree, so one glitch is ignored
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pin
      always_ff @(posedge i_mclk)
      begin
        if (!i_rst_b)
          pin_reg[g] <= PIN_RST[g];
        else if (s2_reg[g] == s3_reg[g])
          pin_reg[g] <= s3_reg[g];
      end
    end
  endgenerate
  logic pen_ok;
  logic access_now;
  logic access_reg;
  assign pen_ok = pin_reg[0];
  assign access_now = !pin_reg[3] && !pin_reg[2] && pin_reg[1];

  // ==========================================
  // controller state
  fps_state_t state_reg;
  fps_state_t state_next;
  logic is_erase_reg;
  logic [31:0] op_cnt_reg;
  logic [31:0] pause_cnt_reg;
  logic [3:0] err_reg;
  logic tune_reg;
  logic any_err;
  logic start_req;
  logic start_ok;
  logic op_done;
  logic paused;
  logic [31:0] ers_len;
  logic [31:0] pause_len;
  assign any_err = |err_reg;
  assign start_req = i_cmd_program || i_cmd_erase;
  // RULE15 RULE16 RULE18 refused starts
  assign start_ok = start_req && (state_reg == ST_IDLE) && pen_ok
                    && !i_block_protected && !any_err;
  assign op_done = (op_cnt_reg == 32'h0000_0001);
  assign pause_len = is_erase_reg ? ERS_PAUSE : PGM_PAUSE;
  assign paused = (pause_cnt_reg >= pause_len);
  // RULE21 erase duration by size
  always_comb
  begin
    unique case (i_erase_size)
      ERS_SZ_SMALL: ers_len = ERS_SMALL;
      ERS_SZ_MID: ers_len = ERS_MID;
      default: ers_len = ERS_LARGE;
    endcase
  end
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start_ok)
          state_next = ST_RUN;
      ST_RUN:
        if (op_done)
          state_next = ST_IDLE;
        else if (i_cmd_suspend)
          state_next = ST_PAUSING;
      // RULE10 finishing beats pausing
      ST_PAUSING:
        if (op_done)
          state_next = ST_IDLE;
        else if (paused)
          state_next = ST_SUSP;
      // RULE12 resume continues
      ST_SUSP:
        if (i_cmd_resume)
          state_next = ST_RUN;
      default:
        state_next = ST_IDLE;
    endcase
  end
  // RULE23 idle after reset
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end
  // remaining time is held across a suspend so resume picks up where it paused
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      op_cnt_reg <= 32'h0000_0000;
      is_erase_reg <= 1'b0;
    end
    else if (start_ok)
    begin
      op_cnt_reg <= i_cmd_erase ? ers_len : PGM_TIME;
      is_erase_reg <= i_cmd_erase;
    end
    else if ((state_reg == ST_RUN) || (state_reg == ST_PAUSING))
      op_cnt_reg <= op_cnt_reg - 32'h0000_0001;
  end
  // RULE19 RULE20 pause latency counter
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      pause_cnt_reg <= 32'h0000_0000;
    else if (state_reg == ST_PAUSING)
      pause_cnt_reg <= pause_cnt_reg + 32'h0000_0001;
    else
      pause_cnt_reg <= 32'h0000_0001;
  end

  // ==========================================
  // sticky errors, order {erase, program, enable pin, protect}
  logic [3:0] err_set;
  always_comb
  begin
    err_set = 4'h0;
    // RULE13 RULE14 verify failure at the end
    if ((state_reg != ST_IDLE) && (state_reg != ST_SUSP) && op_done && i_verify_fail)
      err_set[is_erase_reg ? 3 : 2] = 1'b1;
    if (i_code_check_fail)
      err_set[2] = 1'b1;
    if (start_req && (state_reg == ST_IDLE))
    begin
      // RULE15 enable pin low
      if (!pen_ok)
        err_set[1] = 1'b1;
      // RULE16 protected block
      if (i_block_protected)
        err_set[0] = 1'b1;
      // RULE18 a start with errors pending appears to fail
      if (any_err || !pen_ok || i_block_protected)
        err_set[i_cmd_erase ? 3 : 2] = 1'b1;
    end
  end
  // RULE17 sticky, set wins over clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      err_reg <= 4'h0;
    else if (i_cmd_clear_status)
      err_reg <= err_set;
    else
      err_reg <= err_reg | err_set;
  end
  // RULE22 tuning lock reads locked after reset
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      tune_reg <= 1'b0;
    else
      tune_reg <= i_tuning_unlocked;
  end

  // ==========================================
  // live status and read path
  logic [7:0] status_live;
  always_comb
  begin
    status_live = 8'h00;
    // RULE5 RULE6 busy while running or pausing
    status_live[SB_READY] = o_ready;
    // RULE9 RULE11 suspend flags only in suspend
    status_live[SB_ERS_SUSP] = (state_reg == ST_SUSP) && is_erase_reg;
    status_live[SB_PGM_SUSP] = (state_reg == ST_SUSP) && !is_erase_reg;
    status_live[SB_ERS_FAIL] = err_reg[3];
    status_live[SB_PGM_FAIL] = err_reg[2];
    status_live[SB_PEN_FAIL] = err_reg[1];
    status_live[SB_PROT_FAIL] = err_reg[0];
    status_live[SB_TUNE] = tune_reg;
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      o_ready <= 1'b1;
    else
      o_ready <= (state_next == ST_IDLE) || (state_next == ST_SUSP);
  end
  // RULE3 status mode after commands
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      o_status_mode <= 1'b0;
    else if (start_req || i_cmd_protect || i_cmd_resume || i_cmd_read_status)
      o_status_mode <= 1'b1;
    else if (i_cmd_read_array)
      o_status_mode <= 1'b0;
  end
  // RULE1 RULE2 RULE4 snapshot taken on each new read access, no address used
  // a held access shows a frozen value; the host must toggle to see progress
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      access_reg <= 1'b0;
      o_status_dq <= STATUS_RST;
    end
    else
    begin
      access_reg <= access_now;
      if (access_now && !access_reg)
        o_status_dq <= status_live;
    end
  end
  // ==========================================
  // checks
  // pause cycles are counted here, so latency bounds need no long delay range
  logic [10:0] busy_cnt_reg;
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b || (state_reg != ST_PAUSING))
      busy_cnt_reg <= 11'h000;
    else
      busy_cnt_reg <= busy_cnt_reg + 11'h001;
  end
  sequence s_suspend_taken;
    (state_reg == ST_RUN) && i_cmd_suspend && !op_done;
  endsequence
  property p_busy_on_start;
    start_ok |=> !o_ready;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start) // RULE5
    else $error("ready did not drop on start");
  property p_suspend_busy;
    s_suspend_taken |=> !o_ready && (state_reg == ST_PAUSING);
  endproperty
  a_suspend_busy: assert property (p_suspend_busy) // RULE6
    else $error("suspend did not drop ready");
  property p_pgm_latency;
    (state_reg == ST_PAUSING) && !is_erase_reg |-> busy_cnt_reg < 11'(PGM_SUS_MAX_CYC);
  endproperty
  a_pgm_latency: assert property (p_pgm_latency) // RULE19
    else $error("program pause too slow");
  property p_ers_latency;
    (state_reg == ST_PAUSING) |-> busy_cnt_reg < 11'(ERS_SUS_MAX_CYC);
  endproperty
  a_ers_latency: assert property (p_ers_latency) // RULE20
    else $error("erase pause too slow");
  property p_resume_clears;
    (state_reg == ST_SUSP) && i_cmd_resume |=>
      !status_live[SB_ERS_SUSP] && !status_live[SB_PGM_SUSP] && !o_ready;
  endproperty
  a_resume_clears: assert property (p_resume_clears) // RULE12
    else $error("resume left a suspend flag");
  property p_sticky;
    any_err && !i_cmd_clear_status |=> any_err;
  endproperty
  a_sticky: assert property (p_sticky) // RULE17
    else $error("error flag dropped without clear");
  property p_pen_low;
    start_req && (state_reg == ST_IDLE) && !pen_ok |=> err_reg[1] && o_ready;
  endproperty
  a_pen_low: assert property (p_pen_low) // RULE15
    else $error("enable pin low not flagged");
  property p_protected;
    start_req && (state_reg == ST_IDLE) && i_block_protected |=> err_reg[0];
  endproperty
  a_protected: assert property (p_protected) // RULE16
    else $error("protected block not flagged");
  property p_err_blocks;
    start_req && (state_reg == ST_IDLE) && any_err |=> (state_reg == ST_IDLE);
  endproperty
  a_err_blocks: assert property (p_err_blocks) // RULE18
    else $error("start accepted with errors pending");
  property p_reset_state;
    disable iff (1'b0) !i_rst_b |=> o_ready && (err_reg == 4'h0) && !tune_reg
      && (o_status_dq == STATUS_RST);
  endproperty
  a_reset_state: assert property (p_reset_state) // RULE23
    else $error("reset state wrong");
  property p_refresh;
    access_now && !access_reg |=> o_status_dq == $past(status_live);
  endproperty
  a_refresh: assert property (p_refresh) // RULE4
    else $error("status not refreshed on access");
endmodule : fps_status

// [test/fps_host_model.sv]
// host-side pin model: chip enable, output enable and output disable pins
// assumes the bench clock; status is taken from the data lines after a new access
module fps_host_model
(
  input wire logic i_mclk,
  input wire logic [7:0] i_status_dq,
  output logic o_chip_enable_b,
  output logic o_output_enable_b,
  output logic o_output_disable_pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_chip_enable_b = 1'b0;
    o_output_enable_b = 1'b1;
    o_output_disable_pin_b = 1'b1;
  end
  // ==========================================
  // status read
  // a held access never refreshes, so every read re-opens the access
  task automatic rd(input bit use_od, output logic [7:0] v);
    @(posedge i_mclk);
    if (use_od)
      o_output_disable_pin_b <= 1'b0;
    else
      o_chip_enable_b <= 1'b1;
    o_output_enable_b <= 1'b1;
    // pins pass a synchroniser and filter, so give them time
    repeat (6) @(posedge i_mclk);
    o_chip_enable_b <= 1'b0;
    o_output_disable_pin_b <= 1'b1;
    o_output_enable_b <= 1'b0;
    repeat (8) @(posedge i_mclk);
    v = i_status_dq;
  endtask : rd
endmodule : fps_host_model

// [test/flash_program_erase_status_tb_top.sv]
// self-checking bench for the program/erase status block
// assumes commands arrive as one-cycle pulses; counts are shortened by parameter
module flash_program_erase_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 20;
  localparam int LS = 120;
  localparam int LM = 160;
  localparam int LL = 200;
  localparam int PP = 12;
  localparam int EP = 40;
  logic i_mclk;
  logic i_rst_b;
  logic pen;
  logic [1:0] ers_size;
  logic prot;
  logic vfail;
  logic tune;
  // 0 prog 1 erase 2 protect 3 rd status 4 rd array 5 clear 6 susp 7 resume 8 code fail
  logic [8:0] cmd;
  wire logic ce_b;
  wire logic oe_b;
  wire logic od_b;
  logic [7:0] dq;
  logic mode;
  logic rdy;
  int mismatches;
  int comparisons;
  int n;
  int lens[4] = '{LS, LM, LL, LL};
  initial i_mclk = 1'b0;
  always #12.5 i_mclk = ~i_mclk;
  fps_status #(.ERS_LARGE(LL), .ERS_MID(LM), .ERS_SMALL(LS), .PGM_TIME(LP),
    .PGM_PAUSE(PP), .ERS_PAUSE(EP)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_chip_enable_b(ce_b), .i_output_enable_b(oe_b), .i_output_disable_pin_b(od_b),
    .i_program_erase_enable_pin(pen), .i_cmd_program(cmd[0]), .i_cmd_erase(cmd[1]),
    .i_erase_size(ers_size), .i_cmd_protect(cmd[2]), .i_cmd_read_status(cmd[3]),
    .i_cmd_read_array(cmd[4]), .i_cmd_clear_status(cmd[5]), .i_cmd_suspend(cmd[6]),
    .i_cmd_resume(cmd[7]), .i_block_protected(prot), .i_verify_fail(vfail),
    .i_code_check_fail(cmd[8]), .i_tuning_unlocked(tune), .o_status_dq(dq),
    .o_status_mode(mode), .o_ready(rdy));
  fps_host_model host (.i_mclk(i_mclk), .i_status_dq(dq), .o_chip_enable_b(ce_b),
    .o_output_enable_b(oe_b), .o_output_disable_pin_b(od_b));
  // ==========================================
  // helpers
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic pulse(input int k, input logic [1:0] sz = 2'h0);
    @(posedge i_mclk);
    cmd[k] <= 1'b1;
    ers_size <= sz;
    @(posedge i_mclk);
    cmd <= '0;
    #1;
  endtask : pulse
  task automatic wait_ready();
    n = 0;
    while (rdy !== 1'b1 && n < 5000)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (n >= 5000)
    begin
      mismatches++;
      $display("wrong value ready expected 1 seen stuck low");
      final_report();
    end
  endtask : wait_ready
  // waits for completion and checks the busy time against the expected length
  task automatic dur(input string what, input int len);
    wait_ready();
    chk(what, 8'(n + 3 >= len && n <= len + 1), 8'h01);
  endtask : dur
  task automatic st(input string what, input logic [7:0] exp, input bit od = 0);
    logic [7:0] v;
    host.rd(od, v);
    chk(what, v, exp);
  endtask : st
  task automatic pins(input logic p, input logic b, input logic t);
    @(posedge i_mclk);
    pen <= p;
    prot <= b;
    tune <= t;
    repeat (8) @(posedge i_mclk);
  endtask : pins
  // ==========================================
  // sequence
  initial
  begin
    mismatches = 0;
    comparisons = 0;
    i_rst_b = 1'b0;
    pen = 1'b1;
    ers_size = 2'h0;
    prot = 1'b0;
    vfail = 1'b0;
    tune = 1'b0;
    cmd = '0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    #1;
    chk("ready", 8'(rdy), 8'h01);
    chk("mode", 8'(mode), 8'h00);
    st("reset status", 8'h80);
    $display("test reset done");
    pulse(0);
    chk("busy", 8'(rdy), 8'h00);
    chk("mode", 8'(mode), 8'h01);
    st("busy status", 8'h00);
    wait_ready();
    st("done status", 8'h80);
    pulse(0);
    dur("program time", LP);
    vfail <= 1'b1;
    pulse(0);
    wait_ready();
    vfail <= 1'b0;
    // error flags read only once idle
    st("program fail", 8'h90);
    pulse(0);
    chk("refused", 8'(rdy), 8'h01);
    st("sticky", 8'h90, 1);
    pulse(5);
    st("cleared", 8'h80);
    $display("test program done");
    for (int i = 0; i < 4; i++)
    begin
      pulse(1, 2'(i));
      dur("erase time", lens[i]);
    end
    vfail <= 1'b1;
    pulse(1);
    wait_ready();
    vfail <= 1'b0;
    st("erase fail", 8'hA0);
    pulse(5);
    $display("test erase done");
    pulse(1, 2'h2);
    repeat (10) @(posedge i_mclk);
    pulse(6);
    chk("pausing", 8'(rdy), 8'h00);
    wait_ready();
    chk("erase pause", 8'(n <= EP + 1), 8'h01);
    st("erase susp", 8'hC0);
    pulse(7);
    chk("resumed", 8'(rdy), 8'h00);
    chk("mode", 8'(mode), 8'h01);
    wait_ready();
    st("after resume", 8'h80);
    pulse(0);
    repeat (2) @(posedge i_mclk);
    pulse(6);
    wait_ready();
    chk("program pause", 8'(n <= PP + 1), 8'h01);
    st("program susp", 8'h84);
    pulse(7);
    wait_ready();
    st("after resume", 8'h80);
    pulse(0);
    repeat (LP - 6) @(posedge i_mclk);
    pulse(6);
    wait_ready();
    st("late suspend", 8'h80);
    $display("test suspend done");
    pins(1'b0, 1'b0, 1'b0);
    pulse(0);
    chk("refused", 8'(rdy), 8'h01);
    st("enable low", 8'h98);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    pins(1'b1, 1'b1, 1'b0);
    st("after reset", 8'h80);
    pulse(1);
    st("protected", 8'hA2, 1);
    pulse(5);
    pins(1'b1, 1'b0, 1'b1);
    st("unlocked", 8'h81);
    pulse(8);
    st("code fail", 8'h91);
    pulse(5);
    $display("test flags done");
    pulse(4);
    chk("array mode", 8'(mode), 8'h00);
    pulse(2);
    chk("protect mode", 8'(mode), 8'h01);
    pulse(4);
    pulse(3);
    chk("status mode", 8'(mode), 8'h01);
    $display("test modes done");
    final_report();
  end
endmodule : flash_program_erase_status_tb_top
